// [verilog/stoc_pkg.sv]
package stoc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_STAT   = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_ESR    = 8'h0c;
  localparam logic [7:0] ADDR_ESE    = 8'h10;
  localparam logic [7:0] ADDR_SRE    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_CL = 8'h20;
  localparam logic [7:0] ADDR_MEAS   = 8'h24;

  // Command register bits
  localparam int CMD_TST  = 0;
  localparam int CMD_OPC  = 1;
  localparam int CMD_ESR_CLR = 2;

  // Event status bit positions
  localparam int ESR_OPC  = 0;
  localparam int SRE_ESB  = 5;

  // Interrupt status bits
  localparam int IRQ_TST  = 0;
  localparam int IRQ_OPC  = 1;
  localparam int IRQ_SRQ  = 2;
  localparam int IRQ_W    = 3;

  // Self-test failure unit codes, one bit each
  localparam int FAIL_W   = 13;
  localparam logic [15:0] FAIL_CPU   = 16'h0002;
  localparam logic [15:0] FAIL_ROM   = 16'h0004;
  localparam logic [15:0] FAIL_SNVR  = 16'h0008;
  localparam logic [15:0] FAIL_NVR   = 16'h0010;
  localparam logic [15:0] FAIL_TMR   = 16'h0020;
  localparam logic [15:0] FAIL_RTC   = 16'h0040;
  localparam logic [15:0] FAIL_KEY   = 16'h0080;
  localparam logic [15:0] FAIL_SER   = 16'h0100;
  localparam logic [15:0] FAIL_SBUS  = 16'h0200;
  localparam logic [15:0] FAIL_SIG   = 16'h0400;
  localparam logic [15:0] FAIL_DISP  = 16'h0800;
  localparam logic [15:0] FAIL_MISC  = 16'h1000;
  localparam logic [15:0] FAIL_MASK  = 16'h1ffe;

  localparam int MEAS_W   = 8;

  // Settling time
  localparam int unsigned SETTLE_MS  = 1000;
  localparam int unsigned CLK_MHZ    = 100;
  localparam int unsigned SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SAVE  = 4'b0010,
    ST_TEST  = 4'b0100,
    ST_REST  = 4'b1000
  } stoc_tst_e;

  // Handshake to the self-test engine
  typedef struct packed {
    logic        start;
    logic        save;
    logic        restore;
  } stoc_tctl_s;

  typedef struct packed {
    logic        done;
    logic [15:0] fail;
  } stoc_tres_s;
endpackage

// [verilog/stoc_core.sv]
// Functional notes
// - Self-test query runs tests, result goes to output queue; zero is pass.
// - Failure codes: cpu 2, rom 4, nvram 8/16, timer 32, rtc 64, key 128.
// - More codes: serial 256, bus 512, signaling 1024, display 2048, misc 4096.
// - After a passing self-test, restore settings held before the query.
// - Operation-complete command sets event status bit 0 when ops finish.
// - Command starts one-second timer and asks active measurements to report.
// - Completion needs all active measurements done and timer expired.
// - Awaited measurement off or unavailable: completion never signalled; code hangs only on unavailable, off ones still complete when done.
// - Enabled event bit 0 and service bit 5 give a service request.
//
// Design decisions made here: the APB register port and the address map.
module stoc_core
  import stoc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
)
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // Self-test engine
  output stoc_tctl_s              tst_ctl,
  input  wire stoc_tres_s         tst_res,
  // Measurements
  input  wire logic [MEAS_W-1:0]  meas_active,
  input  wire logic [MEAS_W-1:0]  meas_avail,
  input  wire logic [MEAS_W-1:0]  meas_done,
  output logic                    meas_report_req,
  // Service request and interrupt
  output logic                    srq,
  output logic                    irq
);

  // Measurement flags are asynchronous to pclk: two stages each
  logic [3*MEAS_W-1:0] sync1_q, sync2_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {meas_active, meas_avail, meas_done};
      sync2_q <= sync1_q;
    end
  end
  logic [MEAS_W-1:0] m_act, m_av, m_dn;
  assign {m_act, m_av, m_dn} = sync2_q;

  // Bus decode
  logic acc, wr, rd;
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;
  logic cmd_tst, cmd_opc, cmd_esr_clr, wr_ese, wr_sre, wr_ien, wr_icl;
  assign cmd_tst     = wr && paddr == ADDR_CMD && pwdata[CMD_TST];
  assign cmd_opc     = wr && paddr == ADDR_CMD && pwdata[CMD_OPC];
  assign cmd_esr_clr = wr && paddr == ADDR_CMD && pwdata[CMD_ESR_CLR];
  assign wr_ese      = wr && paddr == ADDR_ESE;
  assign wr_sre      = wr && paddr == ADDR_SRE;
  assign wr_ien      = wr && paddr == ADDR_IRQ_EN;
  assign wr_icl      = wr && paddr == ADDR_IRQ_CL;

  // Self-test sequencer state
  stoc_tst_e   tst_q, tst_d;
  stoc_tctl_s  tctl_q, tctl_d;
  logic [15:0] result_q, result_d;
  logic        rvalid_q, rvalid_d;
  logic        tst_ev;

  // Save settings, test, then restore only on a pass
  always_comb
  begin
    tst_d    = tst_q;
    tctl_d   = '0;
    result_d = result_q;
    rvalid_d = rvalid_q;
    tst_ev   = 1'b0;
    if (rd && paddr == ADDR_RESULT)
      rvalid_d = 1'b0; // Reading pops the one-entry queue
    case (tst_q)
      ST_IDLE:
        if (cmd_tst)
        begin
          tctl_d.save = 1'b1;
          tst_d       = ST_SAVE;
        end
      ST_SAVE:
      begin
        tctl_d.start = 1'b1;
        tst_d        = ST_TEST;
      end
      ST_TEST:
        if (tst_res.done)
        begin
          // Codes already combine by OR across failing units
          result_d = tst_res.fail & FAIL_MASK;
          rvalid_d = 1'b1;
          tst_ev   = 1'b1;
          if ((tst_res.fail & FAIL_MASK) == '0)
          begin
            tctl_d.restore = 1'b1;
            tst_d          = ST_REST;
          end
          else
            tst_d = ST_IDLE;
        end
      ST_REST:
        tst_d = ST_IDLE;
      default:
        tst_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tst_q    <= ST_IDLE;
      tctl_q   <= '0;
      result_q <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      tst_q    <= tst_d;
      tctl_q   <= tctl_d;
      result_q <= result_d;
      rvalid_q <= rvalid_d;
    end
  end
  assign tst_ctl = tctl_q;

  // Operation-complete tracking
  logic        opc_busy_q, opc_busy_d;
  logic [31:0] tmr_q, tmr_d;
  logic [MEAS_W-1:0] wait_q, wait_d;
  logic        hung_q, hung_d;
  logic        req_q, req_d;
  logic        esr_q, esr_d;
  logic        opc_ev;

  always_comb
  begin
    opc_busy_d = opc_busy_q;
    tmr_d      = tmr_q;
    wait_d     = wait_q;
    hung_d     = hung_q;
    req_d      = 1'b0;
    esr_d      = esr_q;
    opc_ev     = 1'b0;
    if (opc_busy_q)
    begin
      if (tmr_q != '0)
        tmr_d = tmr_q - 32'h1;
      // An awaited measurement going away can never finish
      if ((wait_q & ~m_av) != '0)
        hung_d = 1'b1;
      if (tmr_q == '0 && (wait_q & ~m_dn) == '0 && !hung_q)
      begin
        opc_busy_d = 1'b0;
        opc_ev     = 1'b1;
      end
    end
    if (cmd_esr_clr)
      esr_d = 1'b0;
    if (opc_ev)
      esr_d = 1'b1; // set wins over clear
    if (cmd_opc)
    begin
      // Restart: timer and measurement poll run in parallel
      opc_busy_d = 1'b1;
      tmr_d      = SETTLE_CYCLES;
      wait_d     = m_act;
      hung_d     = (m_act & ~m_av) != '0;
      req_d      = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opc_busy_q <= 1'b0;
      tmr_q      <= '0;
      wait_q     <= '0;
      hung_q     <= 1'b0;
      req_q      <= 1'b0;
      esr_q      <= 1'b0;
    end
    else
    begin
      opc_busy_q <= opc_busy_d;
      tmr_q      <= tmr_d;
      wait_q     <= wait_d;
      hung_q     <= hung_d;
      req_q      <= req_d;
      esr_q      <= esr_d;
    end
  end
  assign meas_report_req = req_q;

  // Enables, interrupt status and service request
  logic       ese_q, ese_d, sre_q, sre_d, srq_q, srq_d, irq_q, irq_d;
  logic [IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d, iev;

  always_comb
  begin
    ese_d = wr_ese ? pwdata[ESR_OPC] : ese_q;
    sre_d = wr_sre ? pwdata[SRE_ESB] : sre_q;
    srq_d = esr_q && ese_q && sre_q;
    iev   = '0;
    iev[IRQ_TST] = tst_ev;
    iev[IRQ_OPC] = opc_ev;
    iev[IRQ_SRQ] = srq_d && !srq_q;
    ien_d = wr_ien ? pwdata[IRQ_W-1:0] : ien_q;
    // New events win over a clear in the same cycle
    ist_d = (ist_q & ~(wr_icl ? pwdata[IRQ_W-1:0] : '0)) | iev;
    irq_d = (ist_d & ien_d) != '0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ese_q <= 1'b0;
      sre_q <= 1'b0;
      srq_q <= 1'b0;
      irq_q <= 1'b0;
      ist_q <= '0;
      ien_q <= '0;
    end
    else
    begin
      ese_q <= ese_d;
      sre_q <= sre_d;
      srq_q <= srq_d;
      irq_q <= irq_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
    end
  end
  assign srq = srq_q;
  assign irq = irq_q;

  // Read mux; zero-wait slave, error on unmapped address
  logic [31:0] rdat;
  logic        bad;
  always_comb
  begin
    rdat = '0;
    bad  = 1'b0;
    case (paddr)
      ADDR_CMD:    rdat = '0;
      ADDR_STAT:   rdat = {28'h0, hung_q, opc_busy_q, rvalid_q,
                           tst_q != ST_IDLE};
      ADDR_RESULT: rdat = {16'h0, result_q};
      ADDR_ESR:    rdat = {31'h0, esr_q};
      ADDR_ESE:    rdat = {31'h0, ese_q};
      ADDR_SRE:    rdat = {26'h0, sre_q, 5'h0};
      ADDR_IRQ_ST: rdat = {29'h0, ist_q};
      ADDR_IRQ_EN: rdat = {29'h0, ien_q};
      ADDR_IRQ_CL: rdat = '0;
      ADDR_MEAS:   rdat = {8'h0, m_act, m_av, m_dn};
      default:     bad  = 1'b1;
    endcase
  end

  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= rdat;
      pready_q  <= 1'b1;
      pslverr_q <= bad;
    end
  end
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  // Registered so the pin comes straight from a flop; only valid in access
  assign pslverr = pslverr_q;
endmodule

// [testbench/stoc_core_props.sv]
module stoc_chk
  import stoc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
)
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // Bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  // Engine, measurements, service
  input wire stoc_tctl_s        tst_ctl,
  input wire stoc_tres_s        tst_res,
  input wire logic [MEAS_W-1:0] meas_active,
  input wire logic [MEAS_W-1:0] meas_avail,
  input wire logic              meas_report_req,
  input wire logic              srq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic        acc;
  logic        cmd_wr;
  logic [31:0] age_q;
  logic [31:0] age_d;
  assign acc = psel && penable && pready;
  assign cmd_wr = acc && pwrite && paddr == ADDR_CMD;
  // Age since the report request; saturates so it never wraps
  always_comb
  begin
    age_d = age_q + 32'h1;
    if (meas_report_req)
      age_d = '0;
    else if (age_q == '1)
      age_d = age_q;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age_q <= '0;
    else
      age_q <= age_d;
  end
  tst_save_a: assert property (
    cmd_wr && pwdata[CMD_TST] |-> ##[1:2] tst_ctl.save)
    else $error("no save after test command");
  save_start_a: assert property (tst_ctl.save |=> tst_ctl.start)
    else $error("no start after save");
  result_code_a: assert property (
    acc && !pwrite && paddr == ADDR_RESULT |-> (prdata & 32'hffffe001) == '0)
    else $error("result holds bits outside the codes");
  pass_restore_a: assert property (
    tst_res.done && (tst_res.fail & FAIL_MASK) == '0
    |-> ##[1:3] tst_ctl.restore)
    else $error("no restore after passing test");
  fail_keep_a: assert property (
    tst_res.done && (tst_res.fail & FAIL_MASK) != '0
    |=> (!tst_ctl.restore) [*4])
    else $error("restore after failing test");
  report_req_a: assert property (
    cmd_wr && pwdata[CMD_OPC] |=> meas_report_req)
    else $error("no report request after completion command");
  srq_settle_a: assert property (
    $rose(srq) |-> age_q >= SETTLE_CYCLES - 1)
    else $error("service request before settling time");
  srq_avail_a: assert property (
    $rose(srq) |-> (meas_active & ~meas_avail) == '0)
    else $error("completion with measurement unavailable");
  cover property (tst_ctl.restore);
  cover property ($rose(srq));
  cover property (cmd_wr && pwdata[CMD_OPC]);
endmodule

bind stoc_core stoc_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .tst_ctl, .tst_res, .meas_active, .meas_avail,
  .meas_report_req, .srq);

// [testbench/stoc_eng.sv]
module stoc_eng
  import stoc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Handshake and bench knobs
  input  wire stoc_tctl_s  tst_ctl,
  output stoc_tres_s       tst_res,
  input  wire logic [15:0] inj_fail,
  input  wire logic [3:0]  lat,
  output logic [15:0]      setting_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] saved_q;
  logic [3:0]  cnt_q;
  logic        run_q;
  // Test run of bench-chosen length; it tramples the settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tst_res <= '0;
      setting_q <= 16'h5a3c; // Arbitrary power-up settings
      saved_q <= '0;
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      tst_res.done <= 1'b0;
      tst_res.fail <= ~tst_res.fail; // Idle lines carry no result
      if (tst_ctl.save)
        saved_q <= setting_q;
      if (tst_ctl.start)
      begin
        run_q <= 1'b1;
        cnt_q <= lat;
        setting_q <= ~setting_q;
      end
      else if (run_q && cnt_q == 4'h0)
      begin
        run_q <= 1'b0;
        tst_res.done <= 1'b1;
        tst_res.fail <= inj_fail;
      end
      else if (run_q)
        cnt_q <= cnt_q - 4'h1;
      if (tst_ctl.restore)
        setting_q <= saved_q;
    end
  end
endmodule

// [testbench/stoc_core_tb.sv]
module stoc_core_tb import stoc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SETL = 20;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  stoc_tctl_s  tst_ctl;
  stoc_tres_s  tst_res;
  logic [7:0]  meas_active;
  logic [7:0]  meas_avail;
  logic [7:0]  meas_done;
  logic        meas_report_req;
  logic        srq;
  logic        irq;
  logic [15:0] inj_fail;
  logic [3:0]  lat;
  logic [15:0] setting;
  logic [31:0] rdata;
  logic        rerr;
  logic [31:0] exp_q[$];
  int          error_cnt;
  int          checks_done;

  stoc_core #(.SETTLE_CYCLES(SETL)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .tst_ctl, .tst_res, .meas_active, .meas_avail,
    .meas_done, .meas_report_req, .srq, .irq);
  stoc_eng u_eng (.pclk, .presetn, .tst_ctl, .tst_res, .inj_fail, .lat,
    .setting_q(setting));

  // Half-period toggle gives 100 MHz
  always #5 pclk = ~pclk;

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Setup, then access held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      error_cnt++;
      $display("BAD %0t bus hung", $time);
      wrap_up();
    end
  endtask

  // Bounded poll of one status bit; running out counts an error and ends the run
  task automatic poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, '0);
      n++;
    end
    while (rdata[b] !== 1'b1 && n < 60);
    if (rdata[b] !== 1'b1)
    begin
      error_cnt++;
      $display("BAD %0t poll timed out", $time);
      wrap_up();
    end
  endtask

  // Completion command; the model expects it only when all active ones are available
  task automatic opc(input logic [7:0] act, input logic [7:0] av,
                     input int dly);
    logic want;
    want = (act & ~av) == 8'h0;
    meas_active <= act;
    meas_avail <= av;
    meas_done <= 8'h00;
    apb(1'b1, ADDR_CMD, 32'h4);
    apb(1'b1, ADDR_CMD, 32'h2);
    apb(1'b0, ADDR_ESR, '0);
    chk(rdata, 32'h0);
    repeat (dly) @(posedge pclk);
    if (dly > 0)
    begin
      apb(1'b0, ADDR_ESR, '0);
      chk(rdata, 32'h0);
    end
    meas_done <= act | 8'($urandom);
    if (want)
      poll(ADDR_ESR, ESR_OPC);
    else
      repeat (3 * SETL) @(posedge pclk);
    apb(1'b0, ADDR_ESR, '0);
    chk(rdata, {31'h0, want});
    repeat (2) @(posedge pclk);
    chk({31'h0, srq}, {31'h0, want});
  endtask

  initial
  begin
    logic [15:0] v;
    logic [15:0] pre;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {meas_active, meas_avail, meas_done} = '0;
    inj_fail = '0;
    lat = '0;
    void'($urandom(32'hcab0));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h40, '0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, ADDR_ESR, '0);
    chk(rdata, 32'h0);
    // Each code alone, then a random mix of codes
    for (int i = 0; i < 14; i++)
    begin
      v = (i == 13) ? 16'($urandom) : 16'h1 << i;
      pre = setting;
      inj_fail <= v;
      lat <= 4'($urandom);
      exp_q.push_back({16'h0, v & FAIL_MASK});
      apb(1'b1, ADDR_CMD, 32'h1);
      poll(ADDR_STAT, 1);
      apb(1'b0, ADDR_RESULT, '0);
      chk(rdata, exp_q.pop_front());
      if ((v & FAIL_MASK) == 16'h0)
        chk({16'h0, setting}, {16'h0, pre});
    end
    apb(1'b1, ADDR_ESE, 32'h1);
    apb(1'b1, ADDR_SRE, 32'h20);
    apb(1'b1, ADDR_IRQ_EN, 32'h7);
    opc(8'h03, 8'hff, 0);
    opc(8'h05, 8'hff, 40);
    opc(8'h02, 8'hfd, 0);
    opc(8'h00, 8'h00, 0);
    // Interrupt raised, masked, then cleared
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, ADDR_IRQ_ST, '0);
    chk(rdata & 32'h2, 32'h2);
    apb(1'b1, ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_IRQ_CL, 32'h7);
    apb(1'b1, ADDR_IRQ_EN, 32'h7);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_SRE, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, srq}, 32'h0);
    wrap_up();
  end
endmodule
